// ==== cbt_tx_request_tracker.v ====
// cbt_tx_request_tracker.v - request bookkeeping for the 32 dedicated
// transmit buffers of a can controller, behind an avalon-mm slave.
// assumes scan engine and frame transmitter share clock_i and give
// single-cycle strobes; buffer config and retry mode are static levels.
//
// Overview of operation
// - one pending bit per buffer; set by accepted add, cleared on a good frame end or a cancel.
// - pending bits only ever set for buffers enabled in the config mask.
// - a newly set pending bit starts a scan for the lowest message id.
// - pending bits set during a running scan wait for a later scan.
// - cancelling a buffer added during a scan drops it at once.
// - cancel clears pending; a frame on air delays that to frame end.
// - cancel bit stays until pending clears, and clears on that same edge.
// - cancel done on success, not started, lost arbitration or error.
// - cancelled buffer that still succeeds flags sent and cancel done.
// - with retry disabled, failed frames are cancelled and flagged done.
// - an add for an already pending buffer is ignored.
// - writing one sets an add request, zero does nothing.
// - add bits clear at once when idle, else when the scan ends.
// - add writes only act on configured buffers.
// - writing one sets a cancel request, zero does nothing.
// - cancel writes only act on configured buffers.
// - sent flag sets when pending clears after a good frame.
// - sent flag clears when a new add is written for that buffer.
// - cancel done sets on cancelled clear, clears on a new add.
`timescale 1ns/1ps
`include "cbt_defines.vh"

module cbt_tx_request_tracker (
   input wire clock_i,
   input wire rst_n_i,
   // avalon-mm register slave
   input wire [`CBT_AW-1:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [`CBT_DW-1:0] avs_writedata_i,
   input wire [`CBT_BW-1:0] avs_byteenable_i,
   output reg [`CBT_DW-1:0] avs_readdata_o,
   output reg avs_waitrequest_o,
   // static configuration from the controller
   input wire [`CBT_NBUF-1:0] tx_buffer_config_i,
   input wire auto_retry_disable_i,
   // scan engine handshake
   output reg scan_start_o,
   output wire [`CBT_NBUF-1:0] scan_cand_o,
   input wire scan_done_i,
   // frame transmitter result strobes
   input wire tx_start_i,
   input wire [`CBT_IDXW-1:0] tx_buf_i,
   input wire tx_end_i,
   input wire tx_ok_i
);

   // per-buffer vectors; state and accept bits come from the cells, on-air and write strobes are built here
   wire [`CBT_NBUF-1:0] pending_request_reg;
   wire [`CBT_NBUF-1:0] add_request_reg;
   wire [`CBT_NBUF-1:0] cancel_request_reg;
   wire [`CBT_NBUF-1:0] sent_flags_reg;
   wire [`CBT_NBUF-1:0] cancel_done_reg;
   wire [`CBT_NBUF-1:0] accept_vec;
   wire [`CBT_NBUF-1:0] on_air_vec;
   wire [`CBT_NBUF-1:0] wr_add_vec;
   wire [`CBT_NBUF-1:0] wr_cancel_vec;

   // bus side
   wire bus_req;
   wire bus_done;
   wire wr_hit_add;
   wire wr_hit_cancel;
   wire [`CBT_DW-1:0] be_mask;
   reg [`CBT_DW-1:0] rd_word;

   // scan and frame tracking
   reg scan_busy;
   reg rescan;
   wire any_accept;
   wire scan_go;
   reg air_busy;
   reg [`CBT_IDXW-1:0] air_buf;
   wire start_ok;
   wire [`CBT_DW-1:0] status_word;

   // ---------------- register bus ----------------

   // a request is answered on the edge where waitrequest is seen low
   assign bus_req = avs_read_i | avs_write_i;
   assign bus_done = bus_req & ~avs_waitrequest_o;

   // byte lanes gate the write-one-to-set bits
   assign be_mask = {{8{avs_byteenable_i[3]}},
                     {8{avs_byteenable_i[2]}},
                     {8{avs_byteenable_i[1]}},
                     {8{avs_byteenable_i[0]}}};

   // write strobes fire on the completing edge only
   assign wr_hit_add = avs_write_i & bus_done &
                       (avs_address_i == `CBT_OFS_ADD);
   assign wr_hit_cancel = avs_write_i & bus_done &
                          (avs_address_i == `CBT_OFS_CANCEL);

   // zero bits leave the buffer alone, so many buffers per write
   assign wr_add_vec = wr_hit_add ?
                       (avs_writedata_i & be_mask) :
                       `CBT_RST_WORD;
   assign wr_cancel_vec = wr_hit_cancel ?
                          (avs_writedata_i & be_mask) :
                          `CBT_RST_WORD;

   // one wait cycle per access keeps read data a plain flop
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         avs_waitrequest_o <= 1'b1;
      end else if (bus_req & avs_waitrequest_o) begin
         avs_waitrequest_o <= 1'b0;
      end else begin
         avs_waitrequest_o <= 1'b1;
      end
   end

   // read data latched as waitrequest drops, held until the next read
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         avs_readdata_o <= `CBT_RST_WORD;
      end else if (avs_read_i & avs_waitrequest_o) begin
         avs_readdata_o <= rd_word;
      end
   end

   // status word: scan state and the buffer now on air
   assign status_word = {{(`CBT_DW-`CBT_ST_BUF_HI-1){1'b0}},
                         air_buf,
                         {(`CBT_ST_BUF_LO-`CBT_ST_AIR-1){1'b0}},
                         air_busy,
                         rescan,
                         scan_busy};

   // read decode; unmapped words read as zero and writes vanish
   always @* begin
      if (avs_address_i == `CBT_OFS_PENDING) begin
         rd_word = pending_request_reg;
      end else if (avs_address_i == `CBT_OFS_ADD) begin
         rd_word = add_request_reg;
      end else if (avs_address_i == `CBT_OFS_CANCEL) begin
         rd_word = cancel_request_reg;
      end else if (avs_address_i == `CBT_OFS_SENT) begin
         rd_word = sent_flags_reg;
      end else if (avs_address_i == `CBT_OFS_CDONE) begin
         rd_word = cancel_done_reg;
      end else if (avs_address_i == `CBT_OFS_STATUS) begin
         rd_word = status_word;
      end else begin
         rd_word = `CBT_UNMAPPED;
      end
   end

   // ---------------- scan sequencing ----------------

   // any freshly set pending bit asks for a scan
   assign any_accept = |accept_vec;

   // start now if idle, or chain straight onto the finishing scan
   assign scan_go = (any_accept | rescan) &
                    (~scan_busy | scan_done_i);

   // adds during a scan only arm a follow-up scan, never this one
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         scan_start_o <= 1'b0;
         scan_busy <= 1'b0;
         rescan <= 1'b0;
      end else begin
         scan_start_o <= scan_go;
         if (scan_go) begin
            scan_busy <= 1'b1;
            rescan <= 1'b0;
         end else begin
            if (scan_done_i) begin
               scan_busy <= 1'b0;
            end
            if (any_accept & scan_busy) begin
               rescan <= 1'b1;
            end
         end
      end
   end

   // ---------------- frame tracking ----------------

   // a frame is only tracked for a buffer that is still pending;
   // a stray start for an idle buffer cannot freeze a later cancel
   assign start_ok = tx_start_i & pending_request_reg[tx_buf_i];

   // one-hot of the buffer on air; a start this cycle already shields
   // its buffer from a cancel arriving in the same cycle
   assign on_air_vec = (air_busy ? (`CBT_ONE_HOT << air_buf) :
                        `CBT_RST_WORD) |
                       (start_ok ? (`CBT_ONE_HOT << tx_buf_i) :
                        `CBT_RST_WORD);

   // remember which buffer is on air until the frame ends
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         air_busy <= 1'b0;
         air_buf <= `CBT_RST_IDX;
      end else if (tx_end_i) begin
         air_busy <= 1'b0;
      end else if (start_ok) begin
         air_busy <= 1'b1;
         air_buf <= tx_buf_i;
      end
   end

   // ---------------- per-buffer cells ----------------

   genvar gi;
   generate
      for (gi = 0; gi < `CBT_NBUF; gi = gi + 1) begin : g_buf
         cbt_buffer_cell u_cell (
            .clock_i(clock_i),
            .rst_n_i(rst_n_i),
            .cfg_i(tx_buffer_config_i[gi]),
            .wr_add_i(wr_add_vec[gi]),
            .wr_cancel_i(wr_cancel_vec[gi]),
            .scan_busy_i(scan_busy),
            .scan_done_i(scan_done_i),
            .on_air_i(on_air_vec[gi]),
            .tx_end_i(tx_end_i),
            .tx_ok_i(tx_ok_i),
            .auto_retry_disable_i(auto_retry_disable_i),
            .accept_o(accept_vec[gi]),
            .pending_bit_o(pending_request_reg[gi]),
            .add_bit_o(add_request_reg[gi]),
            .cancel_bit_o(cancel_request_reg[gi]),
            .sent_flag_o(sent_flags_reg[gi]),
            .cancel_done_flag_o(cancel_done_reg[gi]),
            .cand_o(scan_cand_o[gi])
         );
      end
   endgenerate

endmodule // cbt_tx_request_tracker

// ==== cbt_defines.vh ====
// cbt_defines.vh - constants for the transmit buffer request tracker.
// assumes byte addressing on the register bus, one 32-bit word each.
`ifndef CBT_DEFINES_VH
`define CBT_DEFINES_VH

// buffer count and bus geometry
`define CBT_NBUF 32
`define CBT_AW 8
`define CBT_DW 32
`define CBT_BW 4
`define CBT_IDXW 5

// register byte offsets
`define CBT_OFS_PENDING 8'hCC
`define CBT_OFS_ADD 8'hD0
`define CBT_OFS_CANCEL 8'hD4
`define CBT_OFS_SENT 8'hD8
`define CBT_OFS_CDONE 8'hDC
`define CBT_OFS_STATUS 8'hFC

// reset values and fixed read answers
`define CBT_RST_WORD 32'h0000_0000
`define CBT_RST_IDX 5'h00
`define CBT_UNMAPPED 32'h0000_0000
`define CBT_ONE_HOT 32'h0000_0001

// status word field positions
`define CBT_ST_SCAN 0
`define CBT_ST_RESCAN 1
`define CBT_ST_AIR 2
`define CBT_ST_BUF_LO 8
`define CBT_ST_BUF_HI 12

`endif

// ==== cbt_buffer_cell.v ====
// cbt_buffer_cell.v - bookkeeping for one transmit buffer: pending,
// add, cancel, sent and cancel-done bits plus its scan candidate bit.
// assumes write strobes are already decoded and byte-lane qualified.
`timescale 1ns/1ps

module cbt_buffer_cell (
   input wire clock_i,
   input wire rst_n_i,
   input wire cfg_i,
   input wire wr_add_i,
   input wire wr_cancel_i,
   input wire scan_busy_i,
   input wire scan_done_i,
   input wire on_air_i,
   input wire tx_end_i,
   input wire tx_ok_i,
   input wire auto_retry_disable_i,
   output wire accept_o,
   output reg pending_bit_o,
   output reg add_bit_o,
   output reg cancel_bit_o,
   output reg sent_flag_o,
   output reg cancel_done_flag_o,
   output reg cand_o
);

   reg next_pending;
   reg next_add;
   reg next_cancel;
   reg next_sent;
   reg next_cdone;

   // an add for a configured idle buffer is taken, others are dropped
   assign accept_o = wr_add_i & cfg_i & ~pending_bit_o;

   // next state; later assignments take priority, so sets win last
   always @* begin
      next_pending = pending_bit_o;
      next_add = add_bit_o;
      next_sent = sent_flag_o;
      next_cdone = cancel_done_flag_o;
      // add bit only lingers while the scan that excluded it runs
      if (add_bit_o & (~scan_busy_i | scan_done_i)) begin
         next_add = 1'b0;
      end
      if (on_air_i & tx_end_i) begin
         if (tx_ok_i) begin
            next_pending = 1'b0;
            next_sent = 1'b1;
            if (cancel_bit_o) begin
               next_cdone = 1'b1;
            end
         end else if (cancel_bit_o | auto_retry_disable_i) begin
            next_pending = 1'b0;
            next_cdone = 1'b1;
         end
      end else if (cancel_bit_o & ~on_air_i) begin
         // not on air: drop at once, even an add held off by a scan
         next_pending = 1'b0;
         next_add = 1'b0;
         next_cdone = 1'b1;
      end
      // cancel bit lives exactly until the pending bit is gone
      next_cancel = cancel_bit_o & next_pending;
      if (wr_cancel_i & cfg_i) begin
         next_cancel = 1'b1;
      end
      if (accept_o) begin
         next_pending = 1'b1;
         next_add = scan_busy_i & ~scan_done_i;
         next_sent = 1'b0;
         next_cdone = 1'b0;
      end
   end

   // state flops; candidate excludes adds made during a scan
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pending_bit_o <= 1'b0;
         add_bit_o <= 1'b0;
         cancel_bit_o <= 1'b0;
         sent_flag_o <= 1'b0;
         cancel_done_flag_o <= 1'b0;
         cand_o <= 1'b0;
      end else begin
         pending_bit_o <= next_pending;
         add_bit_o <= next_add;
         cancel_bit_o <= next_cancel;
         sent_flag_o <= next_sent;
         cancel_done_flag_o <= next_cdone;
         cand_o <= next_pending & ~next_add;
      end
   end

endmodule // cbt_buffer_cell

// ==== cbt_tracker_checker.sv ====
// port-level assertions for the transmit request tracker
// assumes binding to cbt_tx_request_tracker, one clock, static config
`timescale 1ns/1ps
`include "cbt_defines.vh"

module cbt_tracker_checker (
   input wire clock_i,
   input wire rst_n_i,
   input wire [`CBT_AW-1:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [`CBT_DW-1:0] avs_readdata_o,
   input wire avs_waitrequest_o,
   input wire [`CBT_NBUF-1:0] tx_buffer_config_i,
   input wire auto_retry_disable_i,
   input wire scan_start_o,
   input wire [`CBT_NBUF-1:0] scan_cand_o,
   input wire scan_done_i,
   input wire tx_start_i,
   input wire [`CBT_IDXW-1:0] tx_buf_i,
   input wire tx_end_i,
   input wire tx_ok_i
);
   reg [`CBT_IDXW-1:0] air;
   wire ack = !avs_waitrequest_o;
   wire rd_ok = avs_read_i && ack;
   wire add_wr = avs_write_i && ack && avs_address_i == `CBT_OFS_ADD;
   wire mapped = avs_address_i == `CBT_OFS_PENDING
      || avs_address_i == `CBT_OFS_ADD || avs_address_i == `CBT_OFS_CANCEL
      || avs_address_i == `CBT_OFS_SENT || avs_address_i == `CBT_OFS_CDONE
      || avs_address_i == `CBT_OFS_STATUS;

   // remember which buffer is on air, the end strobe carries no index
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) air <= 5'h00;
      else if (tx_start_i) air <= tx_buf_i;
   end

   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   a_wait_one: assert property (
      (avs_read_i || avs_write_i) && avs_waitrequest_o |=> ack)
      else $error("request not answered after one wait");
   a_wait_pulse: assert property (
      ack |=> avs_waitrequest_o) else $error("waitrequest low too long");
   a_cand_cfg: assert property (
      (scan_cand_o & ~tx_buffer_config_i) == 32'h0000_0000)
      else $error("candidate on unconfigured buffer");
   a_start_cause: assert property (
      scan_start_o |-> $past(add_wr) || $past(scan_done_i))
      else $error("scan started without add or done");
   a_cand_late: assert property (
      |(scan_cand_o & ~$past(scan_cand_o)) |-> scan_start_o)
      else $error("candidate joined a running scan");
   a_ok_drop: assert property (
      tx_end_i && tx_ok_i |=> !scan_cand_o[air])
      else $error("sent buffer still pending");
   a_dar_drop: assert property (
      tx_end_i && !tx_ok_i && auto_retry_disable_i |=> !scan_cand_o[air])
      else $error("failed frame kept with retry off");
   a_unmapped_zero: assert property (
      rd_ok && !mapped |-> avs_readdata_o == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_pend_cfg: assert property (
      rd_ok && avs_address_i == `CBT_OFS_PENDING
      |-> (avs_readdata_o & ~tx_buffer_config_i) == 32'h0000_0000)
      else $error("pending bit on unconfigured buffer");
   a_cdone_cfg: assert property (
      rd_ok && avs_address_i == `CBT_OFS_CDONE
      |-> (avs_readdata_o & ~tx_buffer_config_i) == 32'h0000_0000)
      else $error("cancel done on unconfigured buffer");
endmodule // cbt_tracker_checker

bind cbt_tx_request_tracker cbt_tracker_checker i_cbt_tracker_checker (
   .clock_i(clock_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
   .tx_buffer_config_i(tx_buffer_config_i),
   .auto_retry_disable_i(auto_retry_disable_i),
   .scan_start_o(scan_start_o), .scan_cand_o(scan_cand_o),
   .scan_done_i(scan_done_i), .tx_start_i(tx_start_i),
   .tx_buf_i(tx_buf_i), .tx_end_i(tx_end_i), .tx_ok_i(tx_ok_i));

// ==== cbt_tx_request_tracker_tb_top.sv ====
// self-checking bench for the transmit request tracker
// assumes bench is bus master, scan engine and frame transmitter
`timescale 1ns/1ps
`include "cbt_defines.vh"

module cbt_tx_request_tracker_tb_top;
   reg clock_i = 0, rst_n_i = 0, rd = 0, wr = 0, auto_retry_disable = 0;
   reg sd = 0, ts = 0, te = 0, tok = 0;
   reg [7:0] adr = 8'h00;
   reg [15:0] sp = 16'h0000;
   reg [31:0] wd = 0, cfg = 0, q, m;
   reg [4:0] tb = 5'h00;
   wire [31:0] rdat, cand;
   wire wrq, ss;
   integer fails = 0, tests_run = 0, seed = 24, cyc = 0;

   cbt_tx_request_tracker i_cbt_tx_request_tracker (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
      .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
      .avs_waitrequest_o(wrq), .tx_buffer_config_i(cfg),
      .auto_retry_disable_i(auto_retry_disable), .scan_start_o(ss),
      .scan_cand_o(cand), .scan_done_i(sd), .tx_start_i(ts),
      .tx_buf_i(tb), .tx_end_i(te), .tx_ok_i(tok));

   initial forever #25 clock_i = ~clock_i;

   // scan engine stand-in: long fixed scan so adds can land inside it
   always @(posedge clock_i) begin
      sp <= {sp[14:0], ss};
      sd <= sp[15];
   end

   // hang guard, whole run needs well under a thousand cycles
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fails = fails + 1;
         $display("BAD %0t timeout", $time);
         results;
      end
   end

   // one avalon access, held until waitrequest is seen low
   task bus(input w, input [7:0] a, input [31:0] d);
      begin
         @(posedge clock_i);
         rd <= !w; wr <= w; adr <= a; wd <= d;
         @(posedge clock_i);
         while (wrq !== 1'b0) @(posedge clock_i);
         q = rdat;
         rd <= 0; wr <= 0;
      end
   endtask

   task chk(input [7:0] a, input [31:0] e);
      begin
         bus(0, a, 0);
         tests_run = tests_run + 1;
         if (q !== e) begin
            fails = fails + 1;
            $display("BAD %0t at %h got %h want %h", $time, a, q, e);
         end
      end
   endtask

   // one-cycle start or end strobe of the frame transmitter
   task pulse(input s, input [4:0] b, input ok);
      begin
         @(posedge clock_i);
         ts <= s; te <= !s; tb <= b; tok <= ok;
         @(posedge clock_i);
         ts <= 0; te <= 0;
      end
   endtask

   // wait for the stand-in scan, including a rescan, to go quiet
   task idle;
      begin
         repeat (2) @(posedge clock_i);
         while (sp !== 0 || sd !== 0 || ss !== 0) @(posedge clock_i);
      end
   endtask

   task results;
      begin
         $display("checks %0d fails %0d", tests_run, fails);
         if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
         else $display("Run complete: FAIL");
         $finish;
      end
   endtask

   initial begin
      // buffers 0..3 always configured, 31 never
      cfg = $random(seed) | 32'hF;
      cfg[31] = 0;
      repeat (3) @(posedge clock_i);
      rst_n_i <= 1;
      chk(`CBT_OFS_PENDING, 0);
      chk(`CBT_OFS_SENT, 0);
      chk(`CBT_OFS_CDONE, 0);
      chk(8'h40, 0);
      $display("test reset done");
      repeat (3) begin
         m = $random(seed);
         bus(1, `CBT_OFS_ADD, m);
         idle;
         chk(`CBT_OFS_PENDING, m & cfg);
         bus(1, `CBT_OFS_CANCEL, 32'hFFFFFFFF);
         idle;
         chk(`CBT_OFS_PENDING, 0);
         chk(`CBT_OFS_CDONE, cfg);
         chk(`CBT_OFS_CANCEL, 0);
         bus(1, `CBT_OFS_ADD, m);
         chk(`CBT_OFS_CDONE, cfg & ~m);
         bus(1, `CBT_OFS_CANCEL, 32'hFFFFFFFF);
         idle;
      end
      $display("test random add done");
      // second add and its cancel both land inside the first scan
      bus(1, `CBT_OFS_ADD, 1);
      bus(1, `CBT_OFS_ADD, 2);
      chk(`CBT_OFS_ADD, 2);
      bus(1, `CBT_OFS_CANCEL, 2);
      chk(`CBT_OFS_PENDING, 1);
      chk(`CBT_OFS_CDONE, cfg & ~1);
      idle;
      chk(`CBT_OFS_ADD, 0);
      $display("test scan cancel done");
      pulse(1, 0, 0);
      pulse(0, 0, 1);
      chk(`CBT_OFS_PENDING, 0);
      chk(`CBT_OFS_SENT, 1);
      bus(1, `CBT_OFS_ADD, 1);
      idle;
      chk(`CBT_OFS_SENT, 0);
      pulse(1, 0, 0);
      bus(1, `CBT_OFS_CANCEL, 1);
      chk(`CBT_OFS_PENDING, 1);
      pulse(0, 0, 0);
      chk(`CBT_OFS_PENDING, 0);
      chk(`CBT_OFS_CDONE, cfg);
      $display("test air cancel done");
      bus(1, `CBT_OFS_ADD, 1);
      idle;
      pulse(1, 0, 0);
      bus(1, `CBT_OFS_CANCEL, 1);
      pulse(0, 0, 1);
      chk(`CBT_OFS_SENT, 1);
      chk(`CBT_OFS_CDONE, cfg);
      bus(1, `CBT_OFS_ADD, 1);
      idle;
      pulse(1, 0, 0);
      pulse(0, 0, 0);
      chk(`CBT_OFS_PENDING, 1);
      // add to a still pending buffer must not start a scan
      bus(1, `CBT_OFS_ADD, 1);
      chk(`CBT_OFS_STATUS, 0);
      auto_retry_disable <= 1;
      pulse(1, 0, 0);
      pulse(0, 0, 0);
      chk(`CBT_OFS_PENDING, 0);
      chk(`CBT_OFS_CDONE, cfg);
      $display("test retry mode done");
      results;
   end
endmodule // cbt_tx_request_tracker_tb_top
